// File: include/dac_pkg.sv
package dac_pkg;

  localparam int WORD_BITS  = 16;
  localparam int CODE_BITS  = 12;
  localparam int DATA_BITS  = 10;
  localparam int CHANNELS   = 4;
  localparam int SYNC_BITS  = 5;

  // Field positions inside the shifted word
  localparam int NIBBLE_MSB = 15;
  localparam int NIBBLE_LSB = 12;
  localparam int ADDR_MSB   = 15;
  localparam int ADDR_LSB   = 14;
  localparam int CODE_MSB   = 11;

  // Synchroniser bit positions
  localparam int SYNC_SCLK  = 0;
  localparam int SYNC_CS    = 1;
  localparam int SYNC_DIN   = 2;
  localparam int SYNC_CLR   = 3;
  localparam int SYNC_LOCK  = 4;

  // Synchroniser value after reset: idle level of every pin
  localparam logic [SYNC_BITS-1:0] SYNC_RESET = 5'h1A;

  // Address and command nibbles
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_UPDATE    = 4'h4;
  localparam logic [3:0] CMD_LOAD_ALL  = 4'h8;
  localparam logic [3:0] CMD_SHUTDOWN  = 4'hC;
  localparam logic [3:0] CMD_USER_LO   = 4'h2;
  localparam logic [3:0] CMD_USER_HI   = 4'h6;
  localparam logic [3:0] CMD_EDGE_RISE = 4'hE;
  localparam logic [3:0] CMD_EDGE_FALL = 4'hA;
  localparam logic [1:0] CMD_LOAD_IN   = 2'h1;
  localparam logic [1:0] CMD_LOAD_UPD  = 2'h3;

  // Values after reset or clear
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [11:0] CODE_RESET  = 12'h0000;
  localparam logic        USER_RESET  = 1'b0;
  localparam logic        MODE_RESET  = 1'b0;

  // Settling wait owed by the host after power-up or shutdown exit
  localparam real SETTLE_US     = 20.0;
  localparam real CLOCK_MHZ     = 40.0;
  localparam int  SETTLE_CYCLES = int'(SETTLE_US * CLOCK_MHZ);

  typedef logic [CHANNELS-1:0][CODE_BITS-1:0] codes_t;

  typedef struct packed {
    logic [SYNC_BITS-1:0] stage1;
    logic [SYNC_BITS-1:0] stage2;
  } sync_t;

  typedef struct packed {
    logic                 serial_clock;
    logic                 chip_select_n;
    logic                 serial_data_in;
    logic                 clear_all_n;
    logic                 shutdown_lockout_n;
  } pins_t;

  typedef struct packed {
    logic                 amplifier_enable;
    logic                 reference_pair_one;
    logic                 reference_pair_two;
  } analog_ctl_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
    codes_t               input_reg;
    codes_t               conv_reg;
    logic                 user_out;
    logic                 dout;
    logic                 msb_hold;
    logic                 mode_rising;
    logic                 shutdown;
    logic                 sclk_prev;
    logic                 cs_prev;
  } state_t;

endpackage : dac_pkg

// File: verification/dac_asserts.sv
`timescale 1ns/10ps
module dac_asserts (
  input wire logic                 clock,
  input wire logic                 reset,
  input wire dac_pkg::pins_t       pins,
  input wire logic                 serial_data_out,
  input wire logic                 user_logic_output,
  input wire logic                 shutdown_active,
  input wire logic                 dout_rising_mode,
  input wire dac_pkg::analog_ctl_t analog_ctl,
  input wire dac_pkg::codes_t      converter_code
);
  logic [15:0] sh_q;
  logic [3:0]  nib;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  assign nib = sh_q[15:12];
  // Shadow of the word being received
  always_ff @(posedge clock) begin
    if (reset || !pins.clear_all_n) sh_q <= 16'h0000;
    else if ($rose(pins.serial_clock) && !pins.chip_select_n) sh_q <= {sh_q[14:0], pins.serial_data_in};
  end
  sequence s_word(logic [3:0] n);
    $rose(pins.chip_select_n) && pins.clear_all_n && nib == n;
  endsequence
  sequence s_clr;
    !pins.clear_all_n [*3];
  endsequence
  property p_clear;
    s_clr |=> converter_code == '0 && !user_logic_output && !serial_data_out && !shutdown_active;
  endproperty
  property p_float;
    analog_ctl == {3{!shutdown_active}};
  endproperty
  property p_cause;
    !$stable({user_logic_output, shutdown_active, dout_rising_mode, converter_code}) |->
      ($past(pins.chip_select_n, 3) && !$past(pins.chip_select_n, 4)) || !$past(pins.clear_all_n, 3);
  endproperty
  property p_user;
    s_word(dac_pkg::CMD_USER_LO) or s_word(dac_pkg::CMD_USER_HI) |-> ##3 user_logic_output == sh_q[14];
  endproperty
  property p_sd_on;
    s_word(dac_pkg::CMD_SHUTDOWN) ##0 pins.shutdown_lockout_n |-> ##3 shutdown_active;
  endproperty
  property p_sd_lock;
    s_word(dac_pkg::CMD_SHUTDOWN) ##0 !pins.shutdown_lockout_n |-> ##3 $stable(shutdown_active);
  endproperty
  property p_sd_off;
    s_word(dac_pkg::CMD_UPDATE) or s_word(dac_pkg::CMD_LOAD_ALL) |-> ##3 !shutdown_active;
  endproperty
  property p_load_all;
    s_word(dac_pkg::CMD_LOAD_ALL) |-> ##3 converter_code == {4{sh_q[11:0]}};
  endproperty
  property p_load_in;
    $rose(pins.chip_select_n) && nib[1:0] == dac_pkg::CMD_LOAD_IN |-> ##3 $stable(converter_code);
  endproperty
  property p_edge;
    s_word(dac_pkg::CMD_EDGE_RISE) or s_word(dac_pkg::CMD_EDGE_FALL) |-> ##3 dout_rising_mode == sh_q[14];
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state");
  a_float: assert property (p_float) else $error("enables wrong");
  a_cause: assert property (p_cause) else $error("change without select");
  a_user: assert property (p_user) else $error("user output wrong");
  a_sd_on: assert property (p_sd_on) else $error("no shutdown");
  a_sd_lock: assert property (p_sd_lock) else $error("lockout ignored");
  a_sd_off: assert property (p_sd_off) else $error("no exit");
  a_load_all: assert property (p_load_all) else $error("load all wrong");
  a_load_in: assert property (p_load_in) else $error("converter touched");
  a_edge: assert property (p_edge) else $error("mode wrong");
endmodule : dac_asserts

bind quad_dac_serial_control dac_asserts u_dac_asserts (.clock, .reset, .pins, .serial_data_out,
  .user_logic_output, .shutdown_active, .dout_rising_mode, .analog_ctl, .converter_code);

// File: verification/quad_dac_serial_control_tb.sv
`timescale 1ns/10ps
module quad_dac_serial_control_tb;
  logic                 clock, reset, clr_n, lock_n, sclk, cs_n, din, eusr, esd, emode;
  logic                 serial_data_out, user_logic_output, shutdown_active, dout_rising_mode;
  logic [15:0]          prev, got;
  logic [31:0]          seed;
  int                   n_fail, total_checks, cyc;
  dac_pkg::pins_t       pins;
  dac_pkg::analog_ctl_t analog_ctl;
  dac_pkg::codes_t      converter_code, ein, econv;
  assign pins = {sclk, cs_n, din, clr_n, lock_n};
  quad_dac_serial_control u_quad_dac_serial_control (.clock(clock), .reset(reset), .pins(pins),
    .serial_data_out(serial_data_out), .user_logic_output(user_logic_output),
    .shutdown_active(shutdown_active), .dout_rising_mode(dout_rising_mode),
    .analog_ctl(analog_ctl), .converter_code(converter_code));
  serial_host u_serial_host (.serial_clock(sclk), .chip_select_n(cs_n), .serial_data_in(din),
    .serial_data_out(serial_data_out));
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Expected effect of one word
  function void model(input logic [15:0] w);
    if (w[13:12] == dac_pkg::CMD_LOAD_IN) ein[w[15:14]] = w[11:0];
    else if (w[13:12] == dac_pkg::CMD_LOAD_UPD) begin
      ein[w[15:14]] = w[11:0];
      econv = ein;
    end else case (w[15:12])
      dac_pkg::CMD_UPDATE: {econv, esd} = {ein, 1'h0};
      dac_pkg::CMD_LOAD_ALL: {ein, econv, esd} = {{8{w[11:0]}}, 1'h0};
      dac_pkg::CMD_SHUTDOWN: esd = esd | lock_n;
      dac_pkg::CMD_USER_LO, dac_pkg::CMD_USER_HI: eusr = w[14];
      dac_pkg::CMD_EDGE_RISE, dac_pkg::CMD_EDGE_FALL: {emode, econv} = {w[14], ein};
      default: ;
    endcase
  endfunction : model
  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task word(input logic [15:0] w);
    @(posedge clock);
    #2;
    u_serial_host.send(w, 150 + seed[8:0], got);
    if (emode) chk("dout", got, prev);
    else chk("dout", got[14:0], prev[15:1]);
    prev = w;
    model(w);
    chk("code", converter_code, econv);
    chk("user", user_logic_output, eusr);
    chk("shutdown", shutdown_active, esd);
    chk("mode", dout_rising_mode, emode);
  endtask : word
  task clear_model;
    {ein, econv, eusr, esd, emode, prev} = '0;
  endtask : clear_model
  task complete_run;
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    {reset, clr_n, lock_n, seed} = {3'h7, 32'h5856};
    clear_model;
    repeat (5) @(posedge clock);
    #2 reset = 1'h0;
    repeat (dac_pkg::SETTLE_CYCLES) @(posedge clock);
    chk("reset", {converter_code, user_logic_output, dout_rising_mode, analog_ctl}, 64'h0007);
    for (int n = 0; n < 16; n++) begin
      seed = xs(seed);
      word({n[3:0], seed[11:2], 2'h0});
    end
    @(posedge clock);
    #2 lock_n = 1'h0;
    word(16'h4000);
    word(16'hC000);
    for (int n = 0; n < 60; n++) begin
      seed = xs(seed);
      @(posedge clock);
      #2 lock_n = seed[20];
      word({seed[15:2], 2'h0});
    end
    word(16'h8FFC);
    word(16'h6000);
    @(posedge clock);
    #2 clr_n = 1'h0;
    repeat (4) @(posedge clock);
    chk("clear", {converter_code, user_logic_output, serial_data_out, shutdown_active}, 64'h0000);
    #2 clr_n = 1'h1;
    clear_model;
    repeat (4) @(posedge clock);
    word(16'h0000);
    word(16'h4000);
    complete_run;
  end
endmodule : quad_dac_serial_control_tb

// File: verification/serial_host.sv
`timescale 1ns/10ps
module serial_host (
  output logic      serial_clock,
  output logic      chip_select_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  initial begin
    serial_clock = 1'h0;
    chip_select_n = 1'h1;
    serial_data_in = 1'h0;
  end
  // One frame; gap_ns is the select-high time after it
  task automatic send(input logic [15:0] word, input int gap_ns, output logic [15:0] got);
    chip_select_n = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = word[i];
      #100 serial_clock = 1'h1;
      #100 got[i] = serial_data_out;
      serial_clock = 1'h0;
    end
    #100 chip_select_n = 1'h1;
    serial_data_in = ~serial_data_in;
    #(gap_ns);
  endtask : send
endmodule : serial_host

// File: verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic [dac_pkg::SYNC_BITS-1:0] async_in,
  output logic      [dac_pkg::SYNC_BITS-1:0] sync_out
);

  dac_pkg::sync_t state_q;
  dac_pkg::sync_t state_d;

  always_comb begin
    state_d.stage1 = async_in;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= {dac_pkg::SYNC_RESET, dac_pkg::SYNC_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stage2;

endmodule : pin_sync

// File: verilog/quad_dac_serial_control.sv
`timescale 1ns/10ps
// Functional notes
// - Clear low zeroes registers and outputs, except the analog enables, which go high
// - Chip select low enables serial interface
// - Lockout low blocks software shutdown
// - One 16-bit shift register in and out
// - Input then converter register per channel
// - Code is ten data plus two sub-bits
// - Nibble 1100 enters shutdown if unlocked
// - Shutdown floats amplifiers and both references
// - Serial interface keeps working during shutdown
// - Input registers survive shutdown
// - Update or load-all commands leave shutdown
// - Three write paths by command
// - MSB first: address, command, data, sub-bits
// - Nibble decode for special commands
// - Shift on clock rise, act on select rise
// - Output lags 16.5 or 16 cycles by mode
module quad_dac_serial_control (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire dac_pkg::pins_t       pins,
  output logic                      serial_data_out,
  output logic                      user_logic_output,
  output logic                      shutdown_active,
  output logic                      dout_rising_mode,
  output dac_pkg::analog_ctl_t      analog_ctl,
  output dac_pkg::codes_t           converter_code
);

  dac_pkg::state_t               state_q;
  dac_pkg::state_t               state_d;
  logic [dac_pkg::SYNC_BITS-1:0] pins_raw;
  logic [dac_pkg::SYNC_BITS-1:0] pins_sync;
  logic                          sclk_s;
  logic                          cs_n_s;
  logic                          din_s;
  logic                          clear_n_s;
  logic                          lockout_n_s;
  logic                          sclk_rise;
  logic                          sclk_fall;
  logic                          cs_rise;
  logic [3:0]                    nibble;
  logic [1:0]                    addr;
  logic [dac_pkg::CODE_BITS-1:0] word_code;

  function automatic dac_pkg::codes_t fill_all(input logic [dac_pkg::CODE_BITS-1:0] code);
    dac_pkg::codes_t all;
    for (int i = 0; i < dac_pkg::CHANNELS; i++) begin
      all[i] = code;
    end
    return all;
  endfunction : fill_all

  assign pins_raw[dac_pkg::SYNC_SCLK] = pins.serial_clock;
  assign pins_raw[dac_pkg::SYNC_CS]   = pins.chip_select_n;
  assign pins_raw[dac_pkg::SYNC_DIN]  = pins.serial_data_in;
  assign pins_raw[dac_pkg::SYNC_CLR]  = pins.clear_all_n;
  assign pins_raw[dac_pkg::SYNC_LOCK] = pins.shutdown_lockout_n;

  pin_sync u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign sclk_s      = pins_sync[dac_pkg::SYNC_SCLK];
  assign cs_n_s      = pins_sync[dac_pkg::SYNC_CS];
  assign din_s       = pins_sync[dac_pkg::SYNC_DIN];
  assign clear_n_s   = pins_sync[dac_pkg::SYNC_CLR];
  assign lockout_n_s = pins_sync[dac_pkg::SYNC_LOCK];

  // Edges from synchronised levels
  assign sclk_rise = sclk_s & ~state_q.sclk_prev & ~cs_n_s;
  assign sclk_fall = ~sclk_s & state_q.sclk_prev & ~cs_n_s;
  assign cs_rise   = cs_n_s & ~state_q.cs_prev;

  // Word layout, MSB first
  assign nibble    = state_q.shift[dac_pkg::NIBBLE_MSB:dac_pkg::NIBBLE_LSB];
  assign addr      = state_q.shift[dac_pkg::ADDR_MSB:dac_pkg::ADDR_LSB];
  assign word_code = state_q.shift[dac_pkg::CODE_MSB:0];

  always_comb begin
    state_d           = state_q;
    state_d.sclk_prev = sclk_s;
    state_d.cs_prev   = cs_n_s;
    if (!clear_n_s) begin
      state_d.shift       = dac_pkg::SHIFT_RESET;
      state_d.input_reg   = fill_all(dac_pkg::CODE_RESET);
      state_d.conv_reg    = fill_all(dac_pkg::CODE_RESET);
      state_d.user_out    = dac_pkg::USER_RESET;
      state_d.dout        = 1'b0;
      state_d.msb_hold    = 1'b0;
      state_d.mode_rising = dac_pkg::MODE_RESET;
      state_d.shutdown    = 1'b0;
    end else begin
      // Shifting continues regardless of shutdown
      if (sclk_rise) begin
        state_d.msb_hold = state_q.shift[dac_pkg::WORD_BITS-1];
        state_d.shift    = {state_q.shift[dac_pkg::WORD_BITS-2:0], din_s};
        if (state_q.mode_rising) begin
          state_d.dout = state_q.shift[dac_pkg::WORD_BITS-1];
        end
      end
      if (sclk_fall && !state_q.mode_rising) begin
        state_d.dout = state_q.msb_hold;
      end
      if (cs_rise) begin
        if (nibble[1:0] == dac_pkg::CMD_LOAD_IN) begin
          state_d.input_reg[addr] = word_code;
        end else if (nibble[1:0] == dac_pkg::CMD_LOAD_UPD) begin
          state_d.input_reg[addr] = word_code;
          state_d.conv_reg        = state_d.input_reg;
        end else begin
          unique case (nibble)
            dac_pkg::CMD_UPDATE: begin
              state_d.conv_reg = state_q.input_reg;
              state_d.shutdown = 1'b0;
            end
            dac_pkg::CMD_LOAD_ALL: begin
              state_d.input_reg = fill_all(word_code);
              state_d.conv_reg  = fill_all(word_code);
              state_d.shutdown  = 1'b0;
            end
            dac_pkg::CMD_SHUTDOWN: begin
              if (lockout_n_s) begin
                state_d.shutdown = 1'b1;
              end
            end
            dac_pkg::CMD_USER_LO: begin
              state_d.user_out = 1'b0;
            end
            dac_pkg::CMD_USER_HI: begin
              state_d.user_out = 1'b1;
            end
            dac_pkg::CMD_EDGE_RISE: begin
              state_d.mode_rising = 1'b1;
              state_d.conv_reg    = state_q.input_reg;
            end
            dac_pkg::CMD_EDGE_FALL: begin
              state_d.mode_rising = 1'b0;
              state_d.conv_reg    = state_q.input_reg;
            end
            dac_pkg::CMD_NOP: begin
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q             <= '0;
      state_q.sclk_prev   <= 1'b0;
      state_q.cs_prev     <= 1'b1;
      state_q.mode_rising <= dac_pkg::MODE_RESET;
      state_q.user_out    <= dac_pkg::USER_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign serial_data_out                = state_q.dout;
  assign user_logic_output              = state_q.user_out;
  assign shutdown_active                = state_q.shutdown;
  assign dout_rising_mode               = state_q.mode_rising;
  assign converter_code                 = state_q.conv_reg;
  assign analog_ctl.amplifier_enable    = ~state_q.shutdown;
  assign analog_ctl.reference_pair_one  = ~state_q.shutdown;
  assign analog_ctl.reference_pair_two  = ~state_q.shutdown;

endmodule : quad_dac_serial_control
